// >>> verilog/ccf_common_fifo.sv
// Purpose: common FIFO control of a CAN FD controller, receive or transmit queue
// Assumes: channel signals on the same clock; register port with read data one cycle later
// Notes: depth up to 8 entries held in flip-flops
// What this block does
// - rx mode, condition 0: flag when count rises to threshold from below.
// - tx mode, condition 0: flag when the last queued message is sent.
// - rx mode, condition 1: flag after each stored message.
// - tx mode, condition 1: flag after each successfully sent message.
// - interval reference from peripheral clock, x1 or x10 period per tick.
// - timer source: scaled reference when 0, channel bit time when 1.
// - direction select 0 makes a receive queue, 1 a transmit queue.
// - payload size setting caps data bytes per entry both directions.
// - transmit enable forwards the interrupt while the transmit flag is set.
// - receive enable forwards the interrupt while the receive flag is set.
// - history select 0 logs fifo frames only, 1 also plain buffers.
// - threshold field is a fraction of depth for the threshold interrupt.
// - depth field sets capacity; zero makes the FIFO unusable.
// - link field picks the transmit buffer scan slot of the FIFO.
// - delay field sets interval ticks before each fifo transmission.
`include "ccf_defines.svh"
module ccf_common_fifo
  import ccf_pkg::*;
(
  input wire logic clock, // 20 MHz peripheral clock
  input wire logic rst, // async reset, high
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata_q, // read data, cycle after rd
  output logic irq_q, // fifo interrupt request
  input wire logic rx_valid, // channel stores a received frame
  input wire ccf_entry_t rx_entry, // received frame
  input wire logic bit_tick, // channel bit-time pulse
  output logic tx_valid_q, // frame offered to the channel
  output ccf_entry_t tx_entry_q, // offered frame
  output logic [1:0] tx_slot_q, // scan slot of the offer
  input wire logic tx_done, // a transmission succeeded
  input wire logic tx_from_fifo, // that transmission came from this fifo
  output logic hist_store_q // store a history entry
);
  ccf_cfg_t cfg_q, cfg_d;
  logic hist_src_q;
  logic [1:0] ien_q, flag_q, flag_d;
  ccf_entry_t mem_q [8];
  logic [2:0] wp_q, rp_q;
  logic [3:0] cnt_q, cnt_d;
  ccf_tx_state_t st_q, st_d;
  logic [31:0] rd_d;
  logic t_ready;

  // address decode
  wire w_cfg = wr && addr == `CCF_A_CFG;
  wire w_hist = wr && addr == `CCF_A_HIST;
  wire w_clr = wr && addr == `CCF_A_CLR;
  wire w_ien = wr && addr == `CCF_A_IEN;
  wire w_push = wr && addr == `CCF_A_TXPUSH;
  wire r_pop = rd && addr == `CCF_A_RXPOP;

  // capacity clamps to the storage actually built
  wire [3:0] cap = (cfg_q.depth > `CCF_DEPTH_MAX) ? `CCF_DEPTH_MAX : cfg_q.depth;
  wire usable = cap != 4'h0;
  wire full = cnt_q >= cap;
  wire empty = cnt_q == 4'h0;
  wire is_tx = cfg_q.dir;

  // threshold = depth * (thr+1) / 8, at least one
  wire [7:0] thr_prod = cap * {1'b0, cfg_q.thr} + {4'h0, cap};
  wire [7:0] thr_sh = thr_prod >> `CCF_THR_SHIFT;
  wire [3:0] thr_lvl = (thr_sh[3:0] == 4'h0) ? 4'h1 : thr_sh[3:0];

  // payload limit in bytes
  logic [7:0] pl_max;
  always_comb begin
    case (cfg_q.pls)
      3'h0: pl_max = 8'h08;
      3'h1: pl_max = 8'h0C;
      3'h2: pl_max = 8'h10;
      3'h3: pl_max = 8'h14;
      3'h4: pl_max = 8'h18;
      3'h5: pl_max = 8'h20;
      3'h6: pl_max = 8'h30;
      default: pl_max = 8'h40;
    endcase
  end

  // push source follows the direction
  wire push_req = is_tx ? w_push : rx_valid;
  wire ccf_entry_t push_raw = is_tx ? ccf_entry_t'(wdata) : rx_entry;
  wire ccf_entry_t push_ent = '{id: push_raw.id,
    len: (push_raw.len > pl_max) ? pl_max : push_raw.len};
  // a full or depth-0 fifo drops the frame
  wire push = push_req && usable && !full;
  wire pop_rx = !is_tx && r_pop && !empty;
  wire fifo_sent = st_q == CCF_TX_REQ && tx_done && tx_from_fifo;
  wire pop = pop_rx || fifo_sent;

  assign cnt_d = cnt_q + {3'h0, push} - {3'h0, pop};

  // interrupt events
  wire rx_ev = !is_tx && (cfg_q.ics ? push
    : (cnt_q < thr_lvl && cnt_d >= thr_lvl));
  wire tx_ev = is_tx && fifo_sent
    && (cfg_q.ics || cnt_q == 4'h1);
  // set wins over a clear in the same cycle
  assign flag_d[`CCF_B_RXF] = rx_ev
    || (flag_q[`CCF_B_RXF] && !(w_clr && wdata[`CCF_B_RXF]));
  assign flag_d[`CCF_B_TXF] = tx_ev
    || (flag_q[`CCF_B_TXF] && !(w_clr && wdata[`CCF_B_TXF]));
  // next enables, so a new enable reaches the request in the same cycle as the flags
  wire [1:0] ien_d = w_ien ? wdata[1:0] : ien_q;
  wire irq_d = (flag_d[`CCF_B_RXF] && ien_d[`CCF_B_RXF])
    || (flag_d[`CCF_B_TXF] && ien_d[`CCF_B_TXF]);

  // transmit sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      CCF_TX_IDLE: if (is_tx && usable) st_d = CCF_TX_WAIT;
      CCF_TX_WAIT: begin
        if (!is_tx || !usable) st_d = CCF_TX_IDLE;
        else if (t_ready && !empty) st_d = CCF_TX_REQ;
      end
      CCF_TX_REQ: if (fifo_sent) st_d = CCF_TX_WAIT;
      default: st_d = CCF_TX_IDLE;
    endcase
  end
  // interval restarts on entry and after every fifo frame
  wire t_restart = fifo_sent || st_q == CCF_TX_IDLE;

  ccf_interval u_interval (
    .clock(clock),
    .rst(rst),
    .res(cfg_q.res),
    .src(cfg_q.src),
    .bit_tick(bit_tick),
    .restart(t_restart),
    .delay(cfg_q.delay),
    .ready_q(t_ready)
  );

  // config write, register layout kept separate from the struct
  assign cfg_d = w_cfg ? '{delay: wdata[`CCF_F_DELAY], link: wdata[`CCF_F_LINK],
    thr: wdata[`CCF_F_THR], depth: wdata[`CCF_F_DEPTH], pls: wdata[`CCF_F_PLS],
    src: wdata[`CCF_B_SRC], res: wdata[`CCF_B_RES], ics: wdata[`CCF_B_ICS],
    dir: wdata[`CCF_B_DIR]} : cfg_q;

  // read mux
  wire [31:0] cfg_rd = {cfg_q.delay, 2'h0, cfg_q.link, 1'b0, cfg_q.thr, cfg_q.depth,
    1'b0, cfg_q.pls, 2'h0, cfg_q.src, cfg_q.res, 2'h0, cfg_q.ics, cfg_q.dir};
  wire [31:0] stat_rd = {20'h00000, cnt_q, 4'h0, empty, full, flag_q};
  always_comb begin
    if (!rd) rd_d = 32'h00000000;
    else if (addr == `CCF_A_CFG) rd_d = cfg_rd;
    else if (addr == `CCF_A_HIST) rd_d = {31'h00000000, hist_src_q};
    else if (addr == `CCF_A_STAT) rd_d = stat_rd;
    else if (addr == `CCF_A_IEN) rd_d = {30'h00000000, ien_q};
    else if (addr == `CCF_A_RXPOP) rd_d = (is_tx || empty) ? 32'h00000000 : mem_q[rp_q];
    else rd_d = 32'h00000000;
  end

  // storage, one flop group per entry
  for (genvar i = 0; i < 8; i++) begin : g_ent
    always_ff @(posedge clock or posedge rst) begin
      if (rst) mem_q[i] <= '0;
      else if (push && wp_q == 3'(i)) mem_q[i] <= push_ent;
    end
  end

  // pointers wrap at the configured capacity
  wire [2:0] last = 3'(cap - 4'h1);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      cnt_q <= 4'h0;
    end else if (w_cfg) begin
      // reconfiguring flushes the queue
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      cnt_q <= 4'h0;
    end else begin
      if (push) wp_q <= (wp_q == last) ? 3'h0 : wp_q + 3'h1;
      if (pop) rp_q <= (rp_q == last) ? 3'h0 : rp_q + 3'h1;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_q <= '0;
      hist_src_q <= 1'b0;
      ien_q <= 2'h0;
      flag_q <= 2'h0;
      irq_q <= 1'b0;
      rdata_q <= 32'h00000000;
      st_q <= CCF_TX_IDLE;
    end else begin
      cfg_q <= cfg_d;
      if (w_hist) hist_src_q <= wdata[0];
      ien_q <= ien_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
      rdata_q <= rd_d;
      st_q <= w_cfg ? CCF_TX_IDLE : st_d;
    end
  end

  // channel side outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_valid_q <= 1'b0;
      tx_entry_q <= '0;
      tx_slot_q <= 2'h0;
      hist_store_q <= 1'b0;
    end else begin
      tx_valid_q <= st_d == CCF_TX_REQ && !w_cfg;
      tx_entry_q <= mem_q[rp_q];
      tx_slot_q <= cfg_q.link;
      hist_store_q <= tx_done && ((tx_from_fifo && is_tx) || hist_src_q);
    end
  end

  AST_RX_THR: assert property (@(posedge clock) disable iff (rst)
    (!is_tx && !cfg_q.ics && !w_cfg && cnt_q < thr_lvl && cnt_d >= thr_lvl)
    |=> flag_q[`CCF_B_RXF])
    else $error("threshold crossing did not set receive flag");
  AST_RX_NOFLAG: assert property (@(posedge clock) disable iff (rst)
    (!is_tx && !cfg_q.ics && !push && !flag_q[`CCF_B_RXF]) |=> !flag_q[`CCF_B_RXF])
    else $error("receive flag set without a crossing");
  AST_TX_LAST: assert property (@(posedge clock) disable iff (rst)
    (is_tx && !cfg_q.ics && fifo_sent && cnt_q > 4'h1 && !flag_q[`CCF_B_TXF])
    |=> !flag_q[`CCF_B_TXF])
    else $error("transmit flag set before the last message");
  AST_RX_EACH: assert property (@(posedge clock) disable iff (rst)
    (!is_tx && cfg_q.ics && push) |=> flag_q[`CCF_B_RXF])
    else $error("stored frame did not set receive flag");
  AST_TX_EACH: assert property (@(posedge clock) disable iff (rst)
    (is_tx && cfg_q.ics && fifo_sent) |=> flag_q[`CCF_B_TXF])
    else $error("sent frame did not set transmit flag");
  AST_DIR: assert property (@(posedge clock) disable iff (rst)
    (!is_tx && !w_cfg) |=> !tx_valid_q)
    else $error("receive queue offered a frame");
  AST_PAYLOAD: assert property (@(posedge clock) disable iff (rst)
    push |=> mem_q[$past(wp_q)].len <= $past(pl_max))
    else $error("entry exceeds payload size");
  AST_IRQ: assert property (@(posedge clock) disable iff (rst)
    irq_q == ((flag_q[`CCF_B_RXF] && ien_q[`CCF_B_RXF]) || (flag_q[`CCF_B_TXF] && ien_q[`CCF_B_TXF])))
    else $error("interrupt request disagrees with flags and enables");
  AST_HIST: assert property (@(posedge clock) disable iff (rst)
    (tx_done && !tx_from_fifo && !hist_src_q) |=> !hist_store_q)
    else $error("plain buffer frame logged with select 0");
  AST_DEPTH0: assert property (@(posedge clock) disable iff (rst)
    (!usable && !w_cfg) |=> cnt_q == 4'h0 && !tx_valid_q)
    else $error("depth 0 fifo in use");
  AST_SLOT: assert property (@(posedge clock) disable iff (rst)
    tx_valid_q |-> tx_slot_q == cfg_q.link)
    else $error("offer carries wrong scan slot");
  AST_DELAY: assert property (@(posedge clock) disable iff (rst)
    (st_q == CCF_TX_WAIT && !t_ready) |=> !tx_valid_q)
    else $error("frame offered before interval elapsed");

  // flags stay until software clears them, and rise only on a stored or sent frame
  AST_RX_STICKY: assert property (@(posedge clock) disable iff (rst)
    (flag_q[`CCF_B_RXF] && !(w_clr && wdata[`CCF_B_RXF])) |=> flag_q[`CCF_B_RXF])
    else $error("receive flag dropped without a clear");
  AST_TX_STICKY: assert property (@(posedge clock) disable iff (rst)
    (flag_q[`CCF_B_TXF] && !(w_clr && wdata[`CCF_B_TXF])) |=> flag_q[`CCF_B_TXF])
    else $error("transmit flag dropped without a clear");
  AST_RX_NOPUSH: assert property (@(posedge clock) disable iff (rst)
    (!push && !flag_q[`CCF_B_RXF]) |=> !flag_q[`CCF_B_RXF])
    else $error("receive flag set without a stored frame");
  AST_TX_NOSEND: assert property (@(posedge clock) disable iff (rst)
    (!fifo_sent && !flag_q[`CCF_B_TXF]) |=> !flag_q[`CCF_B_TXF])
    else $error("transmit flag set without a sent frame");

  // an offer must not move under the channel while it is pending, and a full or empty queue keeps its count
  AST_OFFER_HOLD: assert property (@(posedge clock) disable iff (rst)
    (tx_valid_q && !fifo_sent && !w_cfg) |=> tx_valid_q && $stable(tx_entry_q))
    else $error("offer withdrawn or changed before success");
  AST_FULL_HOLD: assert property (@(posedge clock) disable iff (rst)
    (full && !pop && !w_cfg) |=> cnt_q == $past(cnt_q))
    else $error("full fifo took a frame");
  AST_EMPTY_HOLD: assert property (@(posedge clock) disable iff (rst)
    (empty && !push && !w_cfg) |=> empty)
    else $error("empty fifo lost an entry");

  // history requests for both sources
  AST_HIST_FIFO: assert property (@(posedge clock) disable iff (rst)
    (tx_done && tx_from_fifo && is_tx) |=> hist_store_q)
    else $error("fifo frame not logged");
  AST_HIST_PLAIN: assert property (@(posedge clock) disable iff (rst)
    (tx_done && hist_src_q) |=> hist_store_q)
    else $error("plain buffer frame not logged with select 1");
endmodule // ccf_common_fifo

// >>> pkg/ccf_defines.svh
// Purpose: register offsets, field positions and counts of the common FIFO control
// Assumes: 32-bit register port, byte addresses
// Notes: definitions only
`ifndef CCF_DEFINES_SVH
`define CCF_DEFINES_SVH
`define CCF_A_CFG 8'h00
`define CCF_A_HIST 8'h04
`define CCF_A_STAT 8'h08
`define CCF_A_CLR 8'h0C
`define CCF_A_IEN 8'h10
`define CCF_A_RXPOP 8'h14
`define CCF_A_TXPUSH 8'h18
`define CCF_B_DIR 0
`define CCF_B_ICS 1
`define CCF_B_RES 4
`define CCF_B_SRC 5
`define CCF_F_PLS 10:8
`define CCF_F_DEPTH 15:12
`define CCF_F_THR 18:16
`define CCF_F_LINK 21:20
`define CCF_F_DELAY 31:24
`define CCF_B_RXF 0
`define CCF_B_TXF 1
`define CCF_B_FULL 2
`define CCF_B_EMPTY 3
`define CCF_F_CNT 11:8
`define CCF_DEPTH_MAX 4'h8
`define CCF_THR_SHIFT 3
`define CCF_REF_DIV10 4'h9
`endif

// >>> pkg/ccf_pkg.sv
// Purpose: types of the common FIFO control
// Assumes: ccf_defines.svh holds the numbers
// Notes: one entry is a 24-bit identifier and a byte length
package ccf_pkg;
  typedef struct packed {
    logic [23:0] id;
    logic [7:0] len;
  } ccf_entry_t;
  typedef struct packed {
    logic [7:0] delay;
    logic [1:0] link;
    logic [2:0] thr;
    logic [3:0] depth;
    logic [2:0] pls;
    logic src;
    logic res;
    logic ics;
    logic dir;
  } ccf_cfg_t;
  typedef enum logic [1:0] {
    CCF_TX_IDLE = 2'b00,
    CCF_TX_WAIT = 2'b01,
    CCF_TX_REQ = 2'b10
  } ccf_tx_state_t;
endpackage

// >>> verilog/ccf_interval.sv
// Purpose: interval transmission timer of the common FIFO
// Assumes: bit_tick from channel logic on the same clock
// Notes: ready once delay ticks have passed since restart
`include "ccf_defines.svh"
module ccf_interval
  import ccf_pkg::*;
(
  input wire logic clock, // peripheral clock
  input wire logic rst, // async reset, high
  input wire logic res, // reference resolution x1/x10
  input wire logic src, // 0 reference, 1 bit time
  input wire logic bit_tick, // channel bit-time pulse
  input wire logic restart, // start a new interval
  input wire logic [7:0] delay, // interval in ticks
  output logic ready_q // interval elapsed
);
  logic [3:0] pre_q, pre_d;
  logic [7:0] cnt_q, cnt_d;
  wire pre_wrap = (pre_q == `CCF_REF_DIV10);
  wire ref_tick = res ? pre_wrap : 1'b1;
  wire tick = src ? bit_tick : ref_tick;
  assign pre_d = (pre_wrap || !res) ? 4'h0 : pre_q + 4'h1;
  // saturate so a long idle never wraps back below the delay
  assign cnt_d = restart ? 8'h00 : ((tick && cnt_q != 8'hFF) ? cnt_q + 8'h01 : cnt_q);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_q <= 4'h0;
      cnt_q <= 8'h00;
      ready_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      ready_q <= (cnt_d >= delay);
    end
  end
  AST_X10_TICK: assert property (@(posedge clock) disable iff (rst)
    (res && !src && pre_q == 4'h0 && !restart) ##1 !restart [*8] ##1 !restart
    |-> ($past(cnt_q, 9) == 8'hFF) || (cnt_q <= $past(cnt_q, 9) + 8'h01))
    else $error("x10 reference ticks too fast");
  AST_BIT_SRC: assert property (@(posedge clock) disable iff (rst)
    (src && !bit_tick && !restart) |=> cnt_q == $past(cnt_q))
    else $error("timer moved without a bit-time tick");
endmodule // ccf_interval

// >>> bench/ccf_chan_model.sv
// Purpose: channel-side partner of the common FIFO control
// Assumes: same clock as the block; the bit-time clock runs free on the bus
// Notes: answers each fifo offer TX_LAT+1 cycles after it appears
module ccf_chan_model
  import ccf_pkg::*;
#(
  parameter int TICK_DIV = 20,
  parameter int TX_LAT = 8
)(
  input wire logic clock, // peripheral clock
  input wire logic rst, // async reset, high
  output logic rx_valid, // frame stored pulse
  output ccf_entry_t rx_entry, // stored frame
  output logic bit_tick, // bit-time pulse
  input wire logic tx_valid_q, // fifo offer
  output logic tx_done, // success pulse
  output logic tx_from_fifo // success came from the fifo
);
  timeunit 1ns;
  timeprecision 100ps;
  int div = 0;
  int wait_n = 0;
  logic plain_req = 1'h0;
  logic fifo_hit;
  initial begin
    rx_valid = 1'h0;
    rx_entry = '0;
    bit_tick = 1'h0;
    tx_done = 1'h0;
    tx_from_fifo = 1'h0;
  end
  always @(posedge clock) begin
    div <= (div == TICK_DIV - 1) ? 0 : div + 1;
    bit_tick <= (div == TICK_DIV - 1);
  end
  always @(posedge clock) begin
    fifo_hit = tx_valid_q && !tx_done && (wait_n == TX_LAT);
    tx_done <= fifo_hit || plain_req;
    // qualifier is not held outside a success, so it wanders
    tx_from_fifo <= fifo_hit ? 1'h1 : (plain_req ? 1'h0 : ~tx_from_fifo);
    wait_n <= (!rst && tx_valid_q && !tx_done && !fifo_hit) ? wait_n + 1 : 0;
  end
  task send_rx(input ccf_entry_t e);
    @(posedge clock);
    rx_valid <= 1'h1;
    rx_entry <= e;
    @(posedge clock);
    rx_valid <= 1'h0;
    rx_entry <= ~e;
  endtask
  task plain_done;
    @(posedge clock);
    plain_req <= 1'h1;
    @(posedge clock);
    plain_req <= 1'h0;
  endtask
endmodule // ccf_chan_model

// >>> bench/tb_top.sv
// Purpose: self-checking bench of the common FIFO control
// Assumes: channel partner in ccf_chan_model
// Notes: interval windows allow for the prescaler phase
`include "ccf_defines.svh"
module tb_top
  import ccf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [31:0] rdata_q, v;
  logic irq_q, rx_valid, bit_tick, tx_valid_q, tx_done, tx_from_fifo, hist_store_q;
  ccf_entry_t rx_entry, tx_entry_q;
  logic [1:0] tx_slot_q;
  int err_total = 0;
  int checks = 0;
  int hist_n = 0;
  int n, h;
  initial begin
    forever #25 clock = ~clock;
  end
  ccf_common_fifo DUT(.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .irq_q(irq_q), .rx_valid(rx_valid), .rx_entry(rx_entry), .bit_tick(bit_tick), .tx_valid_q(tx_valid_q),
    .tx_entry_q(tx_entry_q), .tx_slot_q(tx_slot_q), .tx_done(tx_done), .tx_from_fifo(tx_from_fifo),
    .hist_store_q(hist_store_q));
  ccf_chan_model chan(.clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_entry(rx_entry), .bit_tick(bit_tick),
    .tx_valid_q(tx_valid_q), .tx_done(tx_done), .tx_from_fifo(tx_from_fifo));
  always @(posedge clock) if (hist_store_q === 1'h1) hist_n <= hist_n + 1;
  function automatic logic [31:0] cfg(input logic dir, ics, res, src, input logic [2:0] pls,
    input logic [3:0] dep, input logic [2:0] thr, input logic [7:0] dly);
    return {dly, 2'h0, 2'h2, 1'h0, thr, dep, 1'h0, pls, 2'h0, src, res, 2'h0, ics, dir};
  endfunction
  function automatic logic [31:0] stat(input logic [3:0] c, input logic e, f, t, r);
    return {20'h0, c, 4'h0, e, f, t, r};
  endfunction
  task complete_run;
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    #1 d = rdata_q;
  endtask
  // sel 1 waits for a success pulse, 0 for an offer; n counts cycles
  task wait_hi(input int sel);
    n = 0;
    #1;
    while (((sel == 1) ? tx_done : tx_valid_q) !== 1'h1) begin
      tick(1);
      n++;
      if (n > 400) begin
        err_total++;
        $display("MISMATCH t=%0t wait ran out", $time);
        complete_run;
      end
    end
  endtask
  task t_rx_each;
    wr_reg(`CCF_A_IEN, 32'h0);
    wr_reg(`CCF_A_CFG, cfg(1'h0, 1'h1, 1'h0, 1'h0, 3'h0, 4'h4, 3'h0, 8'h00));
    wr_reg(`CCF_A_TXPUSH, 32'h0000_0102);
    rd_reg(`CCF_A_STAT, v);
    chk(v, stat(4'h0, 1'h1, 1'h0, 1'h0, 1'h0));
    chan.send_rx({24'h13579B, 8'h0C});
    tick(2);
    rd_reg(`CCF_A_STAT, v);
    chk(v, stat(4'h1, 1'h0, 1'h0, 1'h0, 1'h1));
    chk(32'(irq_q), 32'h0);
    wr_reg(`CCF_A_IEN, 32'h1);
    tick(2);
    chk(32'(irq_q), 32'h1);
    rd_reg(`CCF_A_RXPOP, v);
    chk(v, {24'h13579B, 8'h08});
    wr_reg(`CCF_A_CLR, 32'h1);
    tick(2);
    chk(32'(irq_q), 32'h0);
    chan.send_rx({24'h2468AC, 8'h02});
    tick(2);
    chk(32'(irq_q), 32'h1);
  endtask
  task t_rx_thr;
    wr_reg(`CCF_A_CFG, cfg(1'h0, 1'h0, 1'h0, 1'h0, 3'h7, 4'h8, 3'h3, 8'h00));
    wr_reg(`CCF_A_CLR, 32'h3);
    for (int i = 1; i <= 4; i++) begin
      chan.send_rx({24'(i), 8'h04});
      tick(2);
      rd_reg(`CCF_A_STAT, v);
      chk(v, stat(4'(i), 1'h0, 1'h0, 1'h0, 1'(i == 4)));
    end
    wr_reg(`CCF_A_CLR, 32'h1);
    rd_reg(`CCF_A_RXPOP, v);
    chk(v, {24'h000001, 8'h04});
    chan.send_rx({24'h000005, 8'h04});
    tick(2);
    rd_reg(`CCF_A_STAT, v);
    chk(v, stat(4'h4, 1'h0, 1'h0, 1'h0, 1'h1));
    wr_reg(`CCF_A_CLR, 32'h1);
    chan.send_rx({24'h000006, 8'h04});
    tick(2);
    rd_reg(`CCF_A_STAT, v);
    chk(v, stat(4'h5, 1'h0, 1'h0, 1'h0, 1'h0));
    wr_reg(`CCF_A_CFG, cfg(1'h0, 1'h1, 1'h0, 1'h0, 3'h7, 4'h0, 3'h0, 8'h00));
    wr_reg(`CCF_A_CLR, 32'h3);
    chan.send_rx({24'h000007, 8'h04});
    tick(2);
    rd_reg(`CCF_A_STAT, v);
    chk(32'({v[11:8], v[0]}), 32'h0);
  endtask
  task t_tx;
    wr_reg(`CCF_A_HIST, 32'h0);
    wr_reg(`CCF_A_IEN, 32'h2);
    for (int m = 0; m < 2; m++) begin
      wr_reg(`CCF_A_CFG, cfg(1'h1, 1'(m), 1'h0, 1'h0, 3'h7, 4'h4, 3'h0, 8'h00));
      wr_reg(`CCF_A_CLR, 32'h3);
      h = hist_n;
      wr_reg(`CCF_A_TXPUSH, {24'hA5A5A5, 8'h10});
      wr_reg(`CCF_A_TXPUSH, {24'h5A5A5A, 8'h20});
      wait_hi(0);
      chk(32'(tx_slot_q), 32'h2);
      chk(tx_entry_q, {24'hA5A5A5, 8'h10});
      wait_hi(1);
      tick(2);
      rd_reg(`CCF_A_STAT, v);
      chk(v, stat(4'h1, 1'h0, 1'h0, 1'(m), 1'h0));
      chk(32'(irq_q), 32'(m));
      wait_hi(1);
      tick(2);
      chk(32'(irq_q), 32'h1);
      chk(32'(hist_n - h), 32'h2);
    end
    wr_reg(`CCF_A_IEN, 32'h0);
    tick(2);
    chk(32'(irq_q), 32'h0);
    wr_reg(`CCF_A_HIST, 32'h0);
    h = hist_n;
    chan.plain_done;
    tick(2);
    chk(32'(hist_n - h), 32'h0);
    wr_reg(`CCF_A_HIST, 32'h1);
    chan.plain_done;
    tick(2);
    chk(32'(hist_n - h), 32'h1);
  endtask
  task time_offer(input logic [31:0] c, input int lo, input int hi);
    wr_reg(`CCF_A_CFG, 32'h0);
    wr_reg(`CCF_A_CFG, c);
    wr_reg(`CCF_A_TXPUSH, 32'h0000_0101);
    wait_hi(0);
    chk(32'(n >= lo && n <= hi), 32'h1);
    wait_hi(1);
    tick(1);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    rd_reg(`CCF_A_STAT, v);
    // depth 0 after reset reads as both empty and full
    chk(v, stat(4'h0, 1'h1, 1'h1, 1'h0, 1'h0));
    rd_reg(8'h1C, v);
    chk(v, 32'h0);
    t_rx_each;
    t_rx_thr;
    t_tx;
    time_offer(cfg(1'h1, 1'h0, 1'h0, 1'h0, 3'h7, 4'h4, 3'h0, 8'h05), 1, 8);
    time_offer(cfg(1'h1, 1'h0, 1'h1, 1'h0, 3'h7, 4'h4, 3'h0, 8'h05), 36, 58);
    // timer runs on channel bit time with a delay of 3 ticks
    time_offer(cfg(1'h1, 1'h0, 1'h0, 1'h1, 3'h7, 4'h4, 3'h0, 8'h03), 36, 66);
    complete_run;
  end
endmodule // tb_top
